// ### rtl/tpd_defines.svh
// constants for the tft panel drive timing controller
// assumes a pixel tick clock of six ticks per source sampling period
`ifndef TPD_DEFINES_SVH
`define TPD_DEFINES_SVH

// nominal pixel tick period in ps; six ticks make one sampling period
`define TPD_TICK_PS        17430
`define TPD_TICKS_PER_SMP  6
`define TPD_NS2T(ns)       ((((ns) * 1000) / `TPD_TICK_PS))

// horizontal figures in ns from the line reference point or from an earlier edge; goe fall in sampling periods, pixels as a count
`define TPD_LINE_NS        63500
`define TPD_SOE_ON_NS      1400
`define TPD_SOE_LEN_NS     8000
`define TPD_SSP_NS         9850
`define TPD_VID_NS         10000
`define TPD_SOE_GSC_NS     2300
`define TPD_GSC_HIGH_NS    10300
`define TPD_GOE_RISE_NS    1500
`define TPD_GOE_FALL_SMP   3
`define TPD_PIXELS         480

// horizontal figures in ticks
// line is a whole number of sampling periods so the phase ring never runs short at the wrap
`define TPD_LINE_T     (((`TPD_NS2T(`TPD_LINE_NS)) / `TPD_TICKS_PER_SMP) * `TPD_TICKS_PER_SMP)
`define TPD_SOE_ON_T   (`TPD_NS2T(`TPD_SOE_ON_NS))
`define TPD_SOE_OFF_T  (`TPD_SOE_ON_T + `TPD_NS2T(`TPD_SOE_LEN_NS))
`define TPD_SSP_ON_T   (((`TPD_NS2T(`TPD_SSP_NS)) / 6) * 6 + 3)
`define TPD_SSP_OFF_T  (`TPD_SSP_ON_T + `TPD_TICKS_PER_SMP)
`define TPD_VID_ON_T   (`TPD_NS2T(`TPD_VID_NS))
`define TPD_VID_OFF_T  (`TPD_VID_ON_T + `TPD_PIXELS * `TPD_TICKS_PER_SMP)
`define TPD_GSC_ON_T   (`TPD_SOE_OFF_T + `TPD_NS2T(`TPD_SOE_GSC_NS))
`define TPD_GSC_OFF_T  (`TPD_GSC_ON_T + `TPD_NS2T(`TPD_GSC_HIGH_NS))
`define TPD_GOE_LO_T   (`TPD_GSC_ON_T + `TPD_GOE_FALL_SMP * `TPD_TICKS_PER_SMP)
`define TPD_GOE_HI_T   (`TPD_GSC_ON_T + `TPD_NS2T(`TPD_GOE_RISE_NS))

// field of 262.5 lines: alternate fields of 262 and 263 lines
`define TPD_FIELD_EVEN_LINES 262
`define TPD_FIELD_ODD_LINES  263

`endif

// ### rtl/tpd_pkg.sv
// types for the tft panel drive timing controller
// assumes tpd_defines.svh is on the include path
package tpd_pkg;

   // link (pixel tick) domain state
   typedef struct packed {
      logic [2:0]  cfg_m;
      logic [2:0]  cfg_s;
      logic [1:0]  pin_m;
      logic [1:0]  pin_s;
      logic        ret_p;
      logic [11:0] h;
      logic [8:0]  v;
      logic [2:0]  ring;
      logic        odd;
      logic        warm;
      logic        field_tgl;
      logic [2:0]  phase;
      logic        soe;
      logic        ssp_a;
      logic        ssp_b;
      logic        oe_a;
      logic        oe_b;
      logic        gsc;
      logic [2:0]  goe;
      logic        gsp;
      logic        vid;
      logic        mode_pin;
      logic        dir_pin;
      logic        scan_end;
   } tpd_link_t;

   // system clock domain state
   typedef struct packed {
      logic tgl_m;
      logic tgl_s;
      logic tgl_p;
      logic warm_m;
      logic warm_s;
      logic field_pulse;
      logic ready;
   } tpd_sys_t;

endpackage

// ### rtl/tpd_panel_timing.sv
// timing controller that drives a three-phase analog tft panel
// assumes pix_clk_i runs at six ticks per sampling period, nominally 57.4 MHz
// Operation
// - keep gate output enables high one full field after scanning starts
// - field lasts 262.5 lines on average, no interlace
// - line period is nominally 63.5 us
// - sampling clock period between 100 and 1000 ns
// - sampling clock high and low phases each 47.1 to 57.5 ns
// - phase one to two and two to three offset 31.4 to 38.4 ns
// - source start pulse active 30 to 208 ns
// - source output enable pulse lasts 7.5 to 8.5 us
// - source start pulse rises 1.45 to 10.96 us after line reference
// - valid video starts 1.59 to 11.11 us after line reference
// - source output enable to gate shift clock at least 1.5 us
// - gate output enable rises 1 to 2 us after gate clock rise
// - gate output enable falls 2 to 4 sampling clocks after gate clock rise
// - gate clock period at least 10 us, phases 5 to 58.5 us
// - gate start pulse 5 to 126 us, 2 us margin around edge
// - source output enable and source start pulse apart at least 0.11 us
// - source output enable follows line reference by at most 1.9 us
// - mode high: simultaneous, phases two and three held high
// - direction high drives pin a, reads pin b; low reverses
`include "tpd_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tpd_panel_timing (
   input  wire logic       mclk_i,
   input  wire logic       rst_b_i,
   input  wire logic       enable_i,
   input  wire logic       mode_i,
   input  wire logic       dir_i,
   output var  logic       field_pulse_o,
   output var  logic       panel_ready_o,
   input  wire logic       pix_clk_i,
   output var  logic       sampling_phase_one_o,
   output var  logic       sampling_phase_two_o,
   output var  logic       sampling_phase_three_o,
   output var  logic       source_output_enable_o,
   input  wire logic       source_start_pin_a_i,
   output var  logic       source_start_pin_a_o,
   output var  logic       source_start_pin_a_oe_o,
   input  wire logic       source_start_pin_b_i,
   output var  logic       source_start_pin_b_o,
   output var  logic       source_start_pin_b_oe_o,
   output var  logic       gate_shift_clock_o,
   output var  logic [2:0] gate_output_enable_o,
   output var  logic       gate_start_pulse_o,
   output var  logic       video_valid_o,
   output var  logic       sampling_mode_o,
   output var  logic       horizontal_direction_select_o,
   output var  logic       scan_end_o
);

   localparam logic [11:0] LINE_T  = 12'(`TPD_LINE_T);
   localparam logic [11:0] SOE_ON  = 12'(`TPD_SOE_ON_T);
   localparam logic [11:0] SOE_OFF = 12'(`TPD_SOE_OFF_T);
   localparam logic [11:0] SSP_ON  = 12'(`TPD_SSP_ON_T);
   localparam logic [11:0] SSP_OFF = 12'(`TPD_SSP_OFF_T);
   localparam logic [11:0] VID_ON  = 12'(`TPD_VID_ON_T);
   localparam logic [11:0] VID_OFF = 12'(`TPD_VID_OFF_T);
   localparam logic [11:0] GSC_ON  = 12'(`TPD_GSC_ON_T);
   localparam logic [11:0] GSC_OFF = 12'(`TPD_GSC_OFF_T);
   localparam logic [11:0] GOE_LO  = 12'(`TPD_GOE_LO_T);
   localparam logic [11:0] GOE_HI  = 12'(`TPD_GOE_HI_T);
   localparam logic [2:0]  RING_LAST = 3'(`TPD_TICKS_PER_SMP - 1);
   localparam logic [8:0]  V_LAST_EVEN = 9'(`TPD_FIELD_EVEN_LINES - 1);
   localparam logic [8:0]  V_LAST_ODD  = 9'(`TPD_FIELD_ODD_LINES - 1);

   tpd_pkg::tpd_link_t lk_q;
   tpd_pkg::tpd_link_t lk_d;
   tpd_pkg::tpd_sys_t  sy_q;
   tpd_pkg::tpd_sys_t  sy_d;

   // ---------------- link (pixel tick) domain ----------------
   always_comb begin
      logic       en;
      logic       run;
      logic       mode;
      logic       dir;
      logic       ret;
      logic       line_end;
      logic       in_soe;
      logic       in_ssp;
      logic       in_vid;
      logic       in_gsc;
      logic       in_goe_lo;
      logic [8:0] v_last;
      en        = 1'b0;
      run       = 1'b0;
      mode      = 1'b0;
      dir       = 1'b0;
      ret       = 1'b0;
      line_end  = 1'b0;
      in_soe    = 1'b0;
      in_ssp    = 1'b0;
      in_vid    = 1'b0;
      in_gsc    = 1'b0;
      in_goe_lo = 1'b0;
      v_last    = 9'h000;
      lk_d = lk_q;
      // two-stage synchronisers for controls and panel return pins
      lk_d.cfg_m = {dir_i, mode_i, enable_i};
      lk_d.cfg_s = lk_q.cfg_m;
      lk_d.pin_m = {source_start_pin_b_i, source_start_pin_a_i};
      lk_d.pin_s = lk_q.pin_m;
      en   = lk_q.cfg_s[0];
      mode = lk_q.cfg_s[1];
      dir  = lk_q.cfg_s[2];
      // after enable drops the ring runs on until every started phase has ended
      run       = en | (lk_q.ring != 3'h0) | (lk_q.phase[2] & ~lk_q.mode_pin);
      line_end  = (lk_q.h == LINE_T - 12'h001);
      v_last    = lk_q.odd ? V_LAST_ODD : V_LAST_EVEN;
      // outputs decode the count just left, so the first enabled tick shows h=0
      in_soe    = (lk_q.h >= SOE_ON) & (lk_q.h < SOE_OFF);
      in_ssp    = (lk_q.h >= SSP_ON) & (lk_q.h < SSP_OFF);
      in_vid    = (lk_q.h >= VID_ON) & (lk_q.h < VID_OFF);
      in_gsc    = (lk_q.h >= GSC_ON) & (lk_q.h < GSC_OFF);
      in_goe_lo = (lk_q.h >= GOE_LO) & (lk_q.h < GOE_HI);

      if (!run) begin
         lk_d.h    = 12'h000;
         lk_d.v    = 9'h000;
         lk_d.ring = 3'h0;
         lk_d.odd  = 1'b0;
         lk_d.warm = 1'b0;
      end else begin
         // one tick counter sets the line, one line counter the field
         if (line_end) begin
            lk_d.h    = 12'h000;
            lk_d.ring = 3'h0;
            if (lk_q.v == v_last) begin
               // alternate 262 and 263 line fields
               lk_d.v         = 9'h000;
               lk_d.odd       = ~lk_q.odd;
               lk_d.field_tgl = ~lk_q.field_tgl;
               lk_d.warm      = 1'b1;
            end else begin
               lk_d.v = lk_q.v + 9'h001;
            end
         end else begin
            lk_d.h    = lk_q.h + 12'h001;
            lk_d.ring = (lk_q.ring == RING_LAST) ? 3'h0 : lk_q.ring + 3'h1;
         end
      end

      // six-tick ring: each phase high three ticks, phases two ticks apart
      // outside simultaneous mode a phase starts only while enabled; a started phase always runs its three ticks
      lk_d.phase[0] = (en | lk_q.phase[0]) & (lk_q.ring < 3'h3);
      // simultaneous mode holds phases two and three high
      lk_d.phase[1] = mode | ((en | lk_q.phase[1]) & (lk_q.ring >= 3'h2) & (lk_q.ring <= 3'h4));
      lk_d.phase[2] = mode | (run & (((en | lk_q.phase[2]) & (lk_q.ring >= 3'h4))
                                     | (lk_q.phase[2] & (lk_q.ring == 3'h0))));

      // source output enable window
      lk_d.soe = en & in_soe;

      // start pulse spans one sampling period centred on a phase one edge
      lk_d.ssp_a = en & dir & in_ssp;
      lk_d.ssp_b = en & ~dir & in_ssp;
      // direction picks which start pin is driven
      lk_d.oe_a = dir;
      lk_d.oe_b = ~dir;

      // valid video for 480 sampling periods
      lk_d.vid = en & in_vid;

      // gate shift clock after the output enable gap
      lk_d.gsc = en & in_gsc;

      // gate output enables: low between fall and rise points, high during warm-up
      lk_d.goe = {3{~en | ~lk_q.warm | ~in_goe_lo}};

      // gate start pulse covers line 0, straddling its gate clock rise
      lk_d.gsp = en & (lk_q.v == 9'h000);

      lk_d.mode_pin = mode;
      lk_d.dir_pin  = dir;

      // cascade return from the far start pin marks end of the source scan
      ret            = dir ? lk_q.pin_s[1] : lk_q.pin_s[0];
      lk_d.ret_p     = ret;
      lk_d.scan_end  = en & ret & ~lk_q.ret_p;
   end

   always_ff @(posedge pix_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lk_q      <= '0;
         lk_q.goe  <= 3'h7;
         lk_q.oe_a <= 1'b1;
         // direction shown to the panel agrees with the driven start pin
         lk_q.dir_pin <= 1'b1;
      end else begin
         lk_q <= lk_d;
      end
   end

   // ---------------- system clock domain ----------------
   always_comb begin
      sy_d = sy_q;
      sy_d.tgl_m       = lk_q.field_tgl;
      sy_d.tgl_s       = sy_q.tgl_m;
      sy_d.tgl_p       = sy_q.tgl_s;
      sy_d.warm_m      = lk_q.warm;
      sy_d.warm_s      = sy_q.warm_m;
      sy_d.field_pulse = sy_q.tgl_s ^ sy_q.tgl_p;
      sy_d.ready       = sy_q.warm_s;
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sy_q <= '0;
      end else begin
         sy_q <= sy_d;
      end
   end

   assign field_pulse_o                 = sy_q.field_pulse;
   assign panel_ready_o                 = sy_q.ready;
   assign sampling_phase_one_o          = lk_q.phase[0];
   assign sampling_phase_two_o          = lk_q.phase[1];
   assign sampling_phase_three_o        = lk_q.phase[2];
   assign source_output_enable_o        = lk_q.soe;
   assign source_start_pin_a_o          = lk_q.ssp_a;
   assign source_start_pin_a_oe_o       = lk_q.oe_a;
   assign source_start_pin_b_o          = lk_q.ssp_b;
   assign source_start_pin_b_oe_o       = lk_q.oe_b;
   assign gate_shift_clock_o            = lk_q.gsc;
   assign gate_output_enable_o          = lk_q.goe;
   assign gate_start_pulse_o            = lk_q.gsp;
   assign video_valid_o                 = lk_q.vid;
   assign sampling_mode_o               = lk_q.mode_pin;
   assign horizontal_direction_select_o = lk_q.dir_pin;
   assign scan_end_o                    = lk_q.scan_end;

endmodule

`default_nettype wire

// ### test/tpd_panel_timing_assertions.sv
// checker on the panel timing controller outputs, pixel tick domain
// assumes tpd_defines.svh on the include path
`include "tpd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tpd_panel_timing_assertions (
   input wire logic       rst_b_i,
   input wire logic       pix_clk_i,
   input wire logic       panel_ready_o,
   input wire logic       sampling_phase_one_o,
   input wire logic       sampling_phase_two_o,
   input wire logic       sampling_phase_three_o,
   input wire logic       source_output_enable_o,
   input wire logic       source_start_pin_a_o,
   input wire logic       source_start_pin_b_o,
   input wire logic       source_start_pin_a_oe_o,
   input wire logic       source_start_pin_b_oe_o,
   input wire logic       gate_shift_clock_o,
   input wire logic [2:0] gate_output_enable_o,
   input wire logic       sampling_mode_o,
   input wire logic       horizontal_direction_select_o
);
   wire         ph1 = sampling_phase_one_o;
   wire         soe = source_output_enable_o;
   wire         ssp = source_start_pin_a_o | source_start_pin_b_o;
   wire         gsc = gate_shift_clock_o;
   wire         hdir = horizontal_direction_select_o;
   wire  [2:0]  goe = gate_output_enable_o;
   logic        soe_q;
   logic [11:0] cnt_q;
   // ticks since the source output enable rose, saturating
   always_ff @(posedge pix_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         soe_q <= 1'b0;
         cnt_q <= 12'h000;
      end else begin
         soe_q <= soe;
         cnt_q <= (soe && !soe_q) ? 12'h001 : cnt_q + {11'h000, cnt_q != 12'hFFF};
      end
   end
   default clocking cb @(posedge pix_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   sequence s_ph1_pulse;
      ph1 [*3] ##1 !ph1;
   endsequence
   sequence s_goe_drop;
      (goe == 3'h7) ##1 (goe == 3'h0);
   endsequence
   a_phase_high: assert property ($rose(ph1) |-> s_ph1_pulse)
      else $error("phase one width");
   a_phase_lag: assert property (!sampling_mode_o && $rose(sampling_phase_two_o) |->
      $past(ph1, 2) && !$past(ph1, 3)) else $error("phase lag");
   a_mode_hold: assert property (sampling_mode_o && $past(sampling_mode_o) |->
      sampling_phase_two_o && sampling_phase_three_o) else $error("mode phases");
   a_dir_pins: assert property (hdir != $past(hdir) |=>
      source_start_pin_a_oe_o == hdir && source_start_pin_b_oe_o == !hdir) else $error("pin roles");
   a_soe_width: assert property ($fell(soe) |-> cnt_q == `TPD_SOE_OFF_T - `TPD_SOE_ON_T)
      else $error("enable width");
   a_start_width: assert property ($rose(ssp) |-> ssp [*6] ##1 !ssp)
      else $error("start width");
   a_start_place: assert property ($rose(ssp) |-> !soe && cnt_q == `TPD_SSP_ON_T - `TPD_SOE_ON_T)
      else $error("start place");
   a_gsc_gap: assert property ($rose(gsc) |-> !soe && cnt_q == `TPD_GSC_ON_T - `TPD_SOE_ON_T)
      else $error("gate clock place");
   a_goe_masked: assert property (!panel_ready_o |-> goe == 3'h7)
      else $error("gate enable not held");
   a_goe_fall: assert property ($rose(gsc) && panel_ready_o |-> ##17 s_goe_drop)
      else $error("gate enable fall");
endmodule
bind tpd_panel_timing tpd_panel_timing_assertions u_chk (
   .rst_b_i, .pix_clk_i, .panel_ready_o, .sampling_phase_one_o, .sampling_phase_two_o,
   .sampling_phase_three_o, .source_output_enable_o, .source_start_pin_a_o,
   .source_start_pin_b_o, .source_start_pin_a_oe_o, .source_start_pin_b_oe_o,
   .gate_shift_clock_o, .gate_output_enable_o, .sampling_mode_o, .horizontal_direction_select_o
);
`default_nettype wire

// ### test/tpd_panel_model.sv
// panel model: takes the start pulse on phase one, returns it after a short scan
// assumes the bench resolves both start pins from the enables
`timescale 1ns/1ps
`default_nettype none
module tpd_panel_model #(
   parameter int SCAN = 16
) (
   input  wire logic sampling_phase_one_i,
   input  wire logic horizontal_direction_select_i,
   input  wire logic source_start_pin_a_i,
   input  wire logic source_start_pin_b_i,
   output var  logic carry_o = 1'b0
);
   logic [9:0] cnt_q = 10'h000;
   wire        start = horizontal_direction_select_i ? source_start_pin_a_i
                                                     : source_start_pin_b_i;
   // only phase one clocks the chain, so the simultaneous mode needs nothing else
   always @(posedge sampling_phase_one_i) begin
      if (start)
         cnt_q <= 10'(SCAN);
      else if (cnt_q != 10'h000)
         cnt_q <= cnt_q - 10'h001;
      carry_o <= (cnt_q == 10'h001);
   end
endmodule
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the panel timing controller
// assumes the controller, its checker and the panel model are compiled first
`include "tpd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        mclk_i = 0, pix_clk_i = 0, rst_b_i = 0, enable_i = 0, mode_i = 0, dir_i = 0;
   logic        ph1, ph2, ph3, soe, a_o, a_oe, b_o, b_oe, gsc, gsp, vid, smode, hdir, send, pnl;
   logic        gl = 0, tog = 0;
   logic        rdy, fpl;
   logic [2:0]  goe;
   logic [4:0]  last = 0;
   logic [11:0] h = 0;
   logic [16:0] expq[$];
   int          errors = 0, checks = 0, nend = 0, nfld = 0;
   wire         pa = a_oe ? a_o : !hdir ? pnl : tog;
   wire         pb = b_oe ? b_o : hdir ? pnl : tog;
   wire  [4:0]  vec = {soe, a_o, b_o, vid, gsc};
   always #10 mclk_i = !mclk_i;
   always #62.5 pix_clk_i = !pix_clk_i;
   always @(posedge pix_clk_i) tog <= !tog;
   always @(negedge mclk_i)
      if (fpl === 1'b1)
         nfld++;
   tpd_panel_timing dut (
      .mclk_i, .rst_b_i, .enable_i, .mode_i, .dir_i, .field_pulse_o(fpl), .panel_ready_o(rdy),
      .pix_clk_i, .sampling_phase_one_o(ph1), .sampling_phase_two_o(ph2),
      .sampling_phase_three_o(ph3), .source_output_enable_o(soe),
      .source_start_pin_a_i(pa), .source_start_pin_a_o(a_o), .source_start_pin_a_oe_o(a_oe),
      .source_start_pin_b_i(pb), .source_start_pin_b_o(b_o), .source_start_pin_b_oe_o(b_oe),
      .gate_shift_clock_o(gsc), .gate_output_enable_o(goe), .gate_start_pulse_o(gsp),
      .video_valid_o(vid), .sampling_mode_o(smode), .horizontal_direction_select_o(hdir),
      .scan_end_o(send));
   tpd_panel_model #(.SCAN(16)) u_panel (
      .sampling_phase_one_i(ph1), .horizontal_direction_select_i(hdir),
      .source_start_pin_a_i(pa), .source_start_pin_b_i(pb), .carry_o(pnl));
   task automatic check(input logic [16:0] e, input logic [16:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED at %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic ev(input int t, input logic [4:0] v);
      expq.push_back({t[11:0], v});
   endtask
   // line position counted from the gate start pulse; each edge of the group is compared
   always @(negedge pix_clk_i) begin
      h = (gsp && !gl) || h == `TPD_LINE_T - 1 ? 12'h000 : h + 12'h001;
      gl = gsp;
      if (send === 1'b1)
         nend++;
      if (vec !== last) begin
         check(expq.size() != 0 ? expq.pop_front() : 17'h1FFFF, {h, vec});
         last = vec;
      end
   end
   task automatic run_seg(input logic d, input logic m, input int n);
      int i;
      @(posedge mclk_i);
      dir_i <= d;
      mode_i <= m;
      repeat (8 + $urandom % 8) @(posedge mclk_i);
      nend = 0;
      nfld = 0;
      for (i = 0; i < n; i++) begin
         ev(`TPD_SOE_ON_T, 5'h10);
         ev(`TPD_SOE_OFF_T, 5'h00);
         ev(`TPD_SSP_ON_T, d ? 5'h08 : 5'h04);
         ev(`TPD_SSP_OFF_T, 5'h02);
         ev(`TPD_GSC_ON_T, 5'h03);
         ev(`TPD_GSC_OFF_T, 5'h02);
         ev(`TPD_VID_OFF_T, 5'h00);
      end
      enable_i <= 1'b1;
      for (i = 0; i < 70000 && expq.size() != 0; i++)
         @(posedge mclk_i);
      check(17'h00000, 17'(expq.size()));
      expq.delete();
      enable_i <= 1'b0;
      repeat (100) @(posedge mclk_i);
      check(17'(n), 17'(nend));
      check(17'h00000, 17'(nfld));
      check(17'({m, d, m, m, 3'h7, 1'b0}), 17'({smode, hdir, ph2, ph3, goe, rdy}));
      $display("test dir %0d mode %0d done", d, m);
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      logic d, m;
      void'($urandom(59313));
      repeat (20) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      d = 1'($urandom);
      m = 1'($urandom);
      run_seg(d, m, 2);
      run_seg(!d, !m, 1);
      complete_run();
   end
   initial begin
      #2000000;
      errors++;
      complete_run();
   end
endmodule
`default_nettype wire
